// ===== crs_config_regs.sv
// configuration registers and special-function mapping of the io bus
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`include "crs_defines.svh"
`default_nettype none
// Function
// R1: three ten-bit configuration registers
// R2: per-register set and clear of bits
// R3: control register updates on falling edge
// R4: key controls also steerable from io pins
// R5: line 7 outputs fifo not full
// R6: fixed special-function assignment of lines 1-7
// R7: special function needs matching direction first
// R8: enabled special function overrides control bit
// R9: disabled special function returns to control bit
// R10: io inputs sampled every clock
module crs_config_regs
  import crs_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [7:0]    io_in,
  output crs_io_drv_t        io_drv,
  input  wire logic          fifo_not_full,
  input  wire logic          q_top_out,
  input  wire logic          q_bot_out,
  output crs_int_ctrl_t      int_ctrl
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [9:0] apply_op(input logic [9:0] old, input crs_op_t op,
                                          input logic [9:0] d, input logic [9:0] m);
    unique case (op)
      CRS_OP_SET: apply_op = old | (d & m);
      CRS_OP_CLR: apply_op = old & ~(d & m);
      default:    apply_op = (old & ~m) | (d & m);
    endcase
  endfunction

  function automatic crs_op_t op_of(input logic [7:0] a);
    if (a == `CRS_OFF_CTRL_SET || a == `CRS_OFF_IOC_SET || a == `CRS_OFF_MODE_SET) begin
      op_of = CRS_OP_SET;
    end else if (a == `CRS_OFF_CTRL_CLR || a == `CRS_OFF_IOC_CLR
                 || a == `CRS_OFF_MODE_CLR) begin
      op_of = CRS_OP_CLR;
    end else begin
      op_of = CRS_OP_WRITE;
    end
  endfunction

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        aw_have_r, aw_have_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        w_have_r, w_have_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic [9:0]  ioc_r, ioc_nxt, mode_r, mode_nxt, ctl_r, ctl_nxt;
  logic [7:0]  ior_r, ior_nxt;
  logic        ctl_pend_r, ctl_pend_nxt;
  crs_op_t     pend_op_r, pend_op_nxt;
  logic [9:0]  pend_d_r, pend_d_nxt, pend_m_r, pend_m_nxt;
  logic        wr_fire;
  logic [9:0]  wmask;
  crs_op_t     wop;

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire       = aw_have_r && w_have_r && !bvalid_r;
  assign wmask         = {{2{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wop           = op_of(awaddr_r);

  always_comb begin
    awaddr_nxt   = awaddr_r;
    aw_have_nxt  = aw_have_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    w_have_nxt   = w_have_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    ioc_nxt      = ioc_r;
    mode_nxt     = mode_r;
    ior_nxt      = ior_r;
    ctl_pend_nxt = 1'b0;
    pend_op_nxt  = pend_op_r;
    pend_d_nxt   = pend_d_r;
    pend_m_nxt   = pend_m_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `CRS_RESP_OKAY;
      unique case (awaddr_r)
        // R2: bitwise set and clear
        `CRS_OFF_CTRL, `CRS_OFF_CTRL_SET, `CRS_OFF_CTRL_CLR: begin
          ctl_pend_nxt = 1'b1;
          pend_op_nxt  = wop;
          pend_d_nxt   = wdata_r[9:0];
          pend_m_nxt   = wmask;
        end
        `CRS_OFF_IOC, `CRS_OFF_IOC_SET, `CRS_OFF_IOC_CLR: begin
          ioc_nxt = apply_op(ioc_r, wop, wdata_r[9:0], wmask);
        end
        `CRS_OFF_MODE, `CRS_OFF_MODE_SET, `CRS_OFF_MODE_CLR: begin
          mode_nxt = apply_op(mode_r, wop, wdata_r[9:0], wmask);
        end
        `CRS_OFF_IOR: begin
          ior_nxt = apply_op({2'h0, ior_r}, CRS_OP_WRITE, wdata_r[9:0], wmask) [7:0];
        end
        default: bresp_nxt = `CRS_RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r   <= 8'h00;
      aw_have_r  <= 1'b0;
      wdata_r    <= 32'h0000_0000;
      wstrb_r    <= 4'h0;
      w_have_r   <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= `CRS_RESP_OKAY;
      ioc_r      <= `CRS_CFG_RST;
      mode_r     <= `CRS_CFG_RST;
      ior_r      <= `CRS_IO_RST;
      ctl_pend_r <= 1'b0;
      pend_op_r  <= CRS_OP_WRITE;
      pend_d_r   <= `CRS_CFG_RST;
      pend_m_r   <= `CRS_CFG_RST;
    end else begin
      awaddr_r   <= awaddr_nxt;
      aw_have_r  <= aw_have_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      w_have_r   <= w_have_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      ioc_r      <= ioc_nxt;
      mode_r     <= mode_nxt;
      ior_r      <= ior_nxt;
      ctl_pend_r <= ctl_pend_nxt;
      pend_op_r  <= pend_op_nxt;
      pend_d_r   <= pend_d_nxt;
      pend_m_r   <= pend_m_nxt;
    end
  end

  // ****************************************************************
  // control register, falling edge
  // ****************************************************************
  // pending write stands a whole cycle, so the falling edge applies it once
  always_comb begin
    ctl_nxt = ctl_r;
    if (ctl_pend_r) begin
      ctl_nxt = apply_op(ctl_r, pend_op_r, pend_d_r, pend_m_r);
    end
  end

  // R3: falling edge update
  always_ff @(negedge aclk) begin
    if (!aresetn) begin
      ctl_r <= `CRS_CFG_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ****************************************************************
  // io sampling and special functions
  // ****************************************************************
  logic [7:0]    io_meta_r, io_sync_r, iir_r;
  logic [7:0]    sf_act;
  crs_io_drv_t   io_drv_nxt;
  crs_int_ctrl_t int_nxt;

  // pins pass two flops before anything reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_meta_r <= `CRS_IO_RST;
      io_sync_r <= `CRS_IO_RST;
    end else begin
      io_meta_r <= io_in;
      io_sync_r <= io_meta_r;
    end
  end

  // R7: function active only with matching direction
  // R6: line assignment and directions
  generate
    for (genvar n = 0; n < 8; n++) begin : g_sf
      if (n == `CRS_LN_FIFO_RDY) begin : g_out
        assign sf_act[n] = mode_r[n + `CRS_MODE_OFS] && ioc_r[n];
      end else if (n == `CRS_LN_Q_TOP || n == `CRS_LN_Q_BOT) begin : g_bidir
        assign sf_act[n] = mode_r[n + `CRS_MODE_OFS];
      end else if (n == 0) begin : g_none
        assign sf_act[n] = 1'b0;
      end else begin : g_in
        assign sf_act[n] = mode_r[n + `CRS_MODE_OFS] && !ioc_r[n];
      end
    end
  endgenerate

  always_comb begin
    io_drv_nxt.oe  = ioc_r[7:0];
    io_drv_nxt.out = ior_r;
    // R5: fifo ready on line 7
    if (sf_act[`CRS_LN_FIFO_RDY]) begin
      io_drv_nxt.out[`CRS_LN_FIFO_RDY] = fifo_not_full;
    end
    if (sf_act[`CRS_LN_Q_TOP] && ioc_r[`CRS_LN_Q_TOP]) begin
      io_drv_nxt.out[`CRS_LN_Q_TOP] = q_top_out;
    end
    if (sf_act[`CRS_LN_Q_BOT] && ioc_r[`CRS_LN_Q_BOT]) begin
      io_drv_nxt.out[`CRS_LN_Q_BOT] = q_bot_out;
    end
    // R8: pin overrides control bit
    // R9: control bit when disabled
    // R4: external steering of key controls
    int_nxt.addr_out_enable      = sf_act[`CRS_LN_ADDR_OE] ?
                                   io_sync_r[`CRS_LN_ADDR_OE] : ctl_r[`CRS_LN_ADDR_OE];
    int_nxt.host_addr_out_enable = sf_act[`CRS_LN_HADDR_OE] ?
                                   io_sync_r[`CRS_LN_HADDR_OE] : ctl_r[`CRS_LN_HADDR_OE];
    int_nxt.host_data_out_enable = sf_act[`CRS_LN_HDATA_OE] ?
                                   io_sync_r[`CRS_LN_HDATA_OE] : ctl_r[`CRS_LN_HDATA_OE];
    int_nxt.addr_counter_enable  = sf_act[`CRS_LN_ACNT_EN] ?
                                   io_sync_r[`CRS_LN_ACNT_EN] : ctl_r[`CRS_LN_ACNT_EN];
    int_nxt.q_top_in_valid       = sf_act[`CRS_LN_Q_TOP] && !ioc_r[`CRS_LN_Q_TOP];
    int_nxt.q_top_in             = io_sync_r[`CRS_LN_Q_TOP];
    int_nxt.q_bot_in_valid       = sf_act[`CRS_LN_Q_BOT] && !ioc_r[`CRS_LN_Q_BOT];
    int_nxt.q_bot_in             = io_sync_r[`CRS_LN_Q_BOT];
  end

  // R10: input register every clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iir_r    <= `CRS_IO_RST;
      io_drv   <= '0;
      int_ctrl <= '0;
    end else begin
      iir_r    <= io_sync_r;
      io_drv   <= io_drv_nxt;
      int_ctrl <= int_nxt;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        rvalid_r, rvalid_nxt;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    rvalid_nxt = rvalid_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `CRS_RESP_OKAY;
      unique case (s_axi_araddr)
        `CRS_OFF_CTRL: rdata_nxt = {22'h0, ctl_r};
        `CRS_OFF_IOC:  rdata_nxt = {22'h0, ioc_r};
        `CRS_OFF_MODE: rdata_nxt = {22'h0, mode_r};
        `CRS_OFF_IOR:  rdata_nxt = {24'h0, ior_r};
        `CRS_OFF_IIR:  rdata_nxt = {24'h0, iir_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `CRS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `CRS_RESP_OKAY;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ioc_set;
    wr_fire && awaddr_r == `CRS_OFF_IOC_SET && wstrb_r == 4'hf;
  endsequence

  chk_reg_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0) // R1
    else $error("config read wider than ten bits");
  chk_set_bits: assert property (s_ioc_set |=> ioc_r == ($past(ioc_r) | $past(wdata_r[9:0]))) // R2
    else $error("set instruction lost bits");
  chk_ctrl_update: assert property (ctl_pend_r && pend_op_r == CRS_OP_CLR |=> // R3
      (ctl_r & $past(pend_d_r & pend_m_r)) == 10'h000)
    else $error("control clear not applied at falling edge");
  chk_fifo_ready: assert property (sf_act[7] |=> io_drv.out[7] == $past(fifo_not_full)) // R5
    else $error("fifo ready line wrong");
  chk_pin_override: assert property (sf_act[6] ##1 sf_act[6] |=> // R8
      int_ctrl.addr_out_enable == $past(io_sync_r[6]))
    else $error("pin did not steer address enable");
  chk_ctrl_revert: assert property (!sf_act[5] |=> // R9
      int_ctrl.host_addr_out_enable == $past(ctl_r[5]))
    else $error("control bit not in charge");
  chk_dir_first: assert property (mode_r[7] && ioc_r[6] |=> // R7
      int_ctrl.addr_out_enable == $past(ctl_r[6]))
    else $error("special function active with wrong direction");
  chk_input_sample: assert property (s_axi_arvalid && s_axi_arready && // R10
      s_axi_araddr == `CRS_OFF_IIR |=> s_axi_rdata[7:0] == $past(iir_r))
    else $error("input register read stale");
  chk_ext_line1: assert property (sf_act[1] |=> // R4
      int_ctrl.addr_counter_enable == $past(io_sync_r[1]))
    else $error("counter enable not from pin");
  chk_write_resp: assert property (wr_fire |=> s_axi_bvalid) // write channel handshake
    else $error("write response missing");

endmodule
`default_nettype wire

// ===== crs_defines.svh
// offsets, field positions, reset values and widths for the configuration block
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CRS_OFF_CTRL      8'h00
`define CRS_OFF_CTRL_SET  8'h04
`define CRS_OFF_CTRL_CLR  8'h08
`define CRS_OFF_IOC       8'h0c
`define CRS_OFF_IOC_SET   8'h10
`define CRS_OFF_IOC_CLR   8'h14
`define CRS_OFF_MODE      8'h18
`define CRS_OFF_MODE_SET  8'h1c
`define CRS_OFF_MODE_CLR  8'h20
`define CRS_OFF_IOR       8'h24
`define CRS_OFF_IIR       8'h28

// ****************************************************************
// widths and reset values
// ****************************************************************
`define CRS_CFG_W         10
`define CRS_IO_W          8
`define CRS_CFG_RST       10'h000
`define CRS_IO_RST        8'h00

// ****************************************************************
// io line numbers; mode enable bit of line n is bit n+1
// ****************************************************************
`define CRS_LN_FIFO_RDY   7
`define CRS_LN_ADDR_OE    6
`define CRS_LN_HADDR_OE   5
`define CRS_LN_HDATA_OE   4
`define CRS_LN_Q_TOP      3
`define CRS_LN_Q_BOT      2
`define CRS_LN_ACNT_EN    1
`define CRS_MODE_OFS      1

`define CRS_RESP_OKAY     2'h0
`define CRS_RESP_SLVERR   2'h2

`endif

// ===== crs_pkg.sv
// types shared by the configuration block
`default_nettype none
package crs_pkg;
  typedef enum logic [1:0] {
    CRS_OP_WRITE,
    CRS_OP_SET,
    CRS_OP_CLR
  } crs_op_t;

  // internal controls steered by control bits or by pins
  typedef struct packed {
    logic addr_out_enable;
    logic host_addr_out_enable;
    logic host_data_out_enable;
    logic addr_counter_enable;
    logic q_top_in_valid;
    logic q_top_in;
    logic q_bot_in_valid;
    logic q_bot_in;
  } crs_int_ctrl_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } crs_io_drv_t;
endpackage
`default_nettype wire

// ===== crs_io_partner.sv
// model of the external system logic on the io bus
`default_nettype none
module crs_io_partner
  import crs_pkg::*;
(
  input  wire crs_io_drv_t io_drv,
  input  wire logic [7:0]  drive_val,
  output logic [7:0]       io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // wire resolution
  // ****************************************************************
  // outside logic drives only lines the device releases
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      io_in[i] = io_drv.oe[i] ? io_drv.out[i] : drive_val[i];
    end
  end
endmodule
`default_nettype wire

// ===== crs_config_regs_tb.sv
// self-checking bench for the configuration registers and io special functions
`include "crs_defines.svh"
`default_nettype none
module crs_config_regs_tb
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          aclk = 1'b0;
  logic          aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic          fifo_not_full, q_top_out, q_bot_out, c, p, f, qt;
  logic [7:0]    awaddr, araddr, io_in, drive_val, dv;
  logic [31:0]   wdata, rdata, rd, d, v;
  logic [3:0]    wstrb, s;
  logic [1:0]    bresp, rresp, resp;
  crs_io_drv_t   io_drv;
  crs_int_ctrl_t int_ctrl;
  int            err_total, n_compared, cyc, i, op, k, m;
  int            creg[3];
  int            ln[4] = '{6, 5, 4, 1};

  crs_config_regs dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_in(io_in),
    .io_drv(io_drv), .fifo_not_full(fifo_not_full), .q_top_out(q_top_out),
    .q_bot_out(q_bot_out), .int_ctrl(int_ctrl)
  );
  crs_io_partner u_pins (.io_drv(io_drv), .drive_val(drive_val), .io_in(io_in));

  always #12.5 aclk = ~aclk;

  // ****************************************************************
  // bus tasks and comparison
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] ss,
                    output logic [1:0] r);
    logic ap, wp;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dd;
    wstrb <= ss;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    do begin
      @(posedge aclk);
      if (ap && awready === 1'b1) begin
        awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wvalid <= 1'b0;
        wp = 1'b0;
      end
    end while (ap || wp);
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    dd = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] dd);
    logic [1:0] r;
    wr(a, dd, 4'hf, r);
    chk(r, `CRS_RESP_OKAY);
  endtask

  function automatic logic pick(input crs_int_ctrl_t ic, input int n);
    case (n)
      6: return ic.addr_out_enable;
      5: return ic.host_addr_out_enable;
      4: return ic.host_data_out_enable;
      default: return ic.addr_counter_enable;
    endcase
  endfunction

  task summarize;
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hb28ccc5a));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {fifo_not_full, q_top_out, q_bot_out} = '0;
    {awaddr, araddr, drive_val, wdata, wstrb} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rdr(8'(12 * i), rd, resp);
      chk(rd, 32'h0);
    end
    // plain, set and clear on each ten-bit register, random strobes
    for (i = 0; i < 3; i++) begin
      for (op = 0; op < 6; op++) begin
        d = $urandom;
        s = 4'($urandom);
        m = (s[0] ? 32'hff : 0) | (s[1] ? 32'h300 : 0);
        wr(8'(12 * i + 4 * (op % 3)), d, s, resp);
        chk(resp, `CRS_RESP_OKAY);
        case (op % 3)
          0: creg[i] = (creg[i] & ~m) | (d & m);
          1: creg[i] = creg[i] | (d & m);
          default: creg[i] = creg[i] & ~(d & m);
        endcase
        rdr(8'(12 * i), rd, resp);
        chk(rd, creg[i]);
      end
    end
    rdr(`CRS_OFF_CTRL_SET, rd, resp);
    chk(resp, `CRS_RESP_SLVERR);
    rdr(8'h2c, rd, resp);
    chk(resp, `CRS_RESP_SLVERR);
    wr(8'h2c, 32'h3ff, 4'hf, resp);
    chk(resp, `CRS_RESP_SLVERR);
    // k: 0 function off, 1 on, 2 on with wrong direction
    foreach (ln[j]) begin
      for (k = 0; k < 3; k++) begin
        c = 1'($urandom);
        p = 1'($urandom);
        wreg(`CRS_OFF_CTRL, 32'(c) << ln[j]);
        wreg(`CRS_OFF_IOC, 32'(k == 2) << ln[j]);
        wreg(`CRS_OFF_MODE, 32'(k != 0) << (ln[j] + 1));
        drive_val <= 8'(32'(p) << ln[j]);
        repeat (6) @(posedge aclk);
        chk(pick(int_ctrl, ln[j]), (k == 1) ? p : c);
      end
    end
    wreg(`CRS_OFF_IOC, 32'h88);
    wreg(`CRS_OFF_MODE, 32'h118);
    repeat (4) begin
      f = 1'($urandom);
      qt = 1'($urandom);
      dv = 8'($urandom);
      fifo_not_full <= f;
      q_top_out <= qt;
      q_bot_out <= 1'($urandom);
      drive_val <= dv;
      repeat (6) @(posedge aclk);
      chk(io_drv.oe, 8'h88);
      chk(io_drv.out & 8'h88, {f, 3'h0, qt, 3'h0});
      chk({int_ctrl.q_bot_in_valid, int_ctrl.q_bot_in}, {1'b1, dv[2]});
      rdr(`CRS_OFF_IIR, rd, resp);
      chk(rd, {f, dv[6:4], qt, dv[2:0]});
    end
    v = $urandom;
    wreg(`CRS_OFF_IOR, v);
    wreg(`CRS_OFF_MODE, 32'h0);
    repeat (6) @(posedge aclk);
    chk(io_drv.out & 8'h88, v[7:0] & 8'h88);
    rdr(`CRS_OFF_IOR, rd, resp);
    chk(rd, v[7:0]);
    summarize;
  end
endmodule
`default_nettype wire
